// file: bench/pssp_ctrl_model.sv
// write-data half of the controller that faces the port's data pins
`timescale 1ns/1ns
module pssp_ctrl_model
   import pssp_pkg::*;
(
   // clock and reset
   input  wire logic                    i_clock,
   input  wire logic                    i_sys_rst,
   // transfer requests
   input  wire logic                    i_active,
   input  wire logic                    i_write,
   input  wire logic [PSSP_DATA_W-1:0]  i_wdata,
   // device side of the bus
   input  wire logic [PSSP_DATA_W-1:0]  i_dev_word,
   input  wire logic                    i_dev_oe,
   output logic      [PSSP_DATA_W-1:0]  o_bus
);
   logic [1:0]             wr_q;
   logic [PSSP_DATA_W-1:0] wd0_q;
   logic [PSSP_DATA_W-1:0] wd1_q;
   logic [PSSP_DATA_W-1:0] last_q;

   // data rides two active edges behind its command
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         wr_q <= 2'h0;
      end else if (i_active) begin
         wr_q  <= {wr_q[0], i_write};
         wd1_q <= wd0_q;
         wd0_q <= i_wdata;
      end
      last_q <= i_sys_rst ? '0 : o_bus;
   end

   // a bus nobody drives shows the inverse of its last level
   assign o_bus = wr_q[1] ? wd1_q : (i_dev_oe ? i_dev_word : ~last_q);
endmodule

// file: bench/pssp_port_bench.sv
// self-checking bench for the pipelined sync sram port
`timescale 1ns/1ns
module pssp_port_bench
   import pssp_pkg::*;
;
   logic                   i_clock   = 1'b0;
   logic                   i_sys_rst = 1'b1;
   logic [PSSP_ADDR_W-1:0] addr      = '0;
   logic                   rw        = 1'b1;
   logic                   adv       = 1'b0;
   logic                   sel_a_n   = 1'b1;
   logic                   sel_b_n   = 1'b1;
   logic                   sel_h     = 1'b0;
   logic [3:0]             lanes_n   = 4'hf;
   logic                   hold_n    = 1'b0;
   logic                   order     = 1'b0;
   logic                   oe_n      = 1'b0;
   logic                   sleep     = 1'b0;
   logic                   tck       = 1'b0;
   logic                   tms       = 1'b1;
   logic                   tdi       = 1'b0;
   logic                   trst_n    = 1'b1;
   logic                   wr        = 1'b0;
   logic                   act_q     = 1'b0;
   logic [35:0]            wdata     = '0;
   logic [35:0]            bus;
   logic [35:0]            mem [int];
   logic [35:0]            exp_q [$];
   logic [31:0]            dout;
   logic [3:0]             pout;
   logic                   doe;
   logic                   tdo;
   logic                   tdo_oe;
   int                     fails = 0;
   int                     samples_checked = 0;
   int                     seed = 66035;
   wire                    act = !hold_n && !sleep;

   always #50 i_clock = ~i_clock;

   pssp_port pssp_port_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_address(addr), .i_read_write(rw), .i_advance_or_load(adv),
      .i_select_low_a(sel_a_n), .i_select_low_b(sel_b_n),
      .i_select_high(sel_h), .i_byte_lane_write_n(lanes_n),
      .i_clock_hold_n(hold_n), .i_burst_order_select(order),
      .i_output_enable_n(oe_n), .i_sleep_request(sleep),
      .i_data_pins(bus[31:0]), .i_byte_parity_pins(bus[35:32]),
      .o_data_pins(dout), .o_byte_parity_pins(pout), .o_data_oe(doe),
      .i_test_clock(tck), .i_test_mode(tms), .i_test_data(tdi),
      .i_test_reset_n(trst_n), .o_test_out(tdo), .o_test_out_oe(tdo_oe));

   pssp_ctrl_model pssp_ctrl_model_i (.i_clock(i_clock),
      .i_sys_rst(i_sys_rst), .i_active(act), .i_write(wr),
      .i_wdata(wdata), .i_dev_word({pout, dout}), .i_dev_oe(doe),
      .o_bus(bus));

   task automatic compare_word(input logic [35:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: word %h not %h", $time, got, exp);
      end
   endtask

   task automatic compare_bit(input logic got, exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: flag %b not %b", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      if (exp_q.size() != 0) begin
         fails++;
         $display("wrong value at %0t: reads never answered", $time);
      end
      $display("checked %0d, wrong %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   function automatic logic [35:0] lane_mask(input logic [3:0] ln);
      lane_mask = '0;
      for (int k = 0; k < 4; k++)
         if (!ln[k])
            lane_mask |= {4'h1 << k, 32'hff << (8 * k)};
   endfunction

   // one command cycle; sl is {low a, low b, high}, 001 selects
   task automatic cmd(input logic a_adv, a_rw, input logic [2:0] sl,
                      input int a, input logic [3:0] ln);
      logic [35:0] w;
      logic        sel;
      w = 36'({$random(seed), $random(seed)});
      sel = (sl == 3'b001);
      @(posedge i_clock);
      adv <= a_adv;
      rw <= a_rw;
      {sel_a_n, sel_b_n, sel_h} <= sl;
      addr <= a_adv ? 19'($random(seed)) : 19'(a);
      lanes_n <= ln;
      wr <= sel && !a_rw;
      wdata <= w;
      if (sel && a_rw)
         exp_q.push_back(mem[a]);
      if (sel && !a_rw)
         mem[a] = (mem[a] & ~lane_mask(ln)) | (w & lane_mask(ln));
   endtask

   task automatic burst(input logic a_rw, input int b, input logic [3:0] ln);
      for (int n = 0; n < 4; n++)
         cmd(n != 0, a_rw, 3'b001, order ? (b ^ n) :
             ((b & ~3) | ((b + n) & 3)), ln);
   endtask

   // outputs must stand still while edges are held
   task automatic freeze(input logic as_sleep, input int n);
      logic [36:0] seen;
      @(posedge i_clock);
      hold_n <= !as_sleep;
      sleep <= as_sleep;
      {sel_a_n, sel_b_n, sel_h} <= 3'b000;
      adv <= 1'b0;
      wr <= 1'b0;
      @(posedge i_clock);
      #1 seen = {doe, pout, dout};
      repeat (n) begin
         @(posedge i_clock);
         #1 compare_word({pout, dout}, seen[35:0]);
         compare_bit(doe, seen[36]);
      end
      @(posedge i_clock);
      hold_n <= 1'b0;
      sleep <= 1'b0;
   endtask

   task automatic tck_cycle(input logic m, d);
      @(posedge i_clock);
      tms <= m;
      tdi <= d;
      repeat (2) @(posedge i_clock);
      tck <= 1'b1;
      repeat (2) @(posedge i_clock);
      tck <= 1'b0;
      repeat (2) @(posedge i_clock);
      #1;
   endtask

   // read data is owed only after an active edge
   always @(posedge i_clock) act_q <= act && !i_sys_rst;
   always @(negedge i_clock) begin
      if (act_q && doe !== 1'b0) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("wrong value at %0t: bus driven unasked", $time);
         end else begin
            compare_word({pout, dout}, exp_q.pop_front());
         end
      end
   end

   initial begin
      repeat (30000) @(posedge i_clock);
      fails++;
      tally_and_finish;
   end

   initial begin
      repeat (16) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++)
         cmd(0, 0, 3'b001, i, 4'h0);
      for (int i = 0; i < 8; i++)
         cmd(0, 1, 3'b001, 7 - i, 4'($random(seed)));
      for (int i = 0; i < 4; i++) begin
         cmd(0, 0, 3'b001, 3, ~(4'h1 << i));
         cmd(0, 1, 3'b001, 3, 4'h0);
      end
      // a write issued while unselected must not land
      for (int s = 0; s < 8; s++) begin
         cmd(0, 1, 3'b001, 2, 4'hf);
         if (s != 1)
            cmd(0, 0, 3'(s), 5, 4'h0);
      end
      cmd(0, 1, 3'b001, 5, 4'h0);
      for (int o = 0; o < 2; o++) begin
         repeat (3) cmd(0, 1, 3'b000, 0, 4'hf);
         i_sys_rst <= 1'b1;
         order <= o[0];
         @(posedge i_clock);
         i_sys_rst <= 1'b0;
         for (int b = 0; b < 4; b++) begin
            burst(0, 8 + b, 4'h0);
            burst(1, 8 + ((b + 1) & 3), 4'($random(seed)));
         end
      end
      cmd(0, 0, 3'b001, 20, 4'h0);
      cmd(0, 1, 3'b001, 8, 4'h0);
      cmd(0, 1, 3'b001, 20, 4'h0);
      freeze(0, 5);
      cmd(0, 1, 3'b001, 9, 4'h0);
      cmd(0, 0, 3'b001, 21, 4'h0);
      freeze(1, 6);
      cmd(0, 1, 3'b001, 21, 4'h0);
      repeat (4) cmd(0, 1, 3'b000, 0, 4'hf);
      oe_n <= 1'b1;
      cmd(0, 1, 3'b001, 21, 4'h0);
      repeat (2) cmd(0, 1, 3'b000, 0, 4'hf);
      @(posedge i_clock);
      #20 compare_bit(doe, 1'b0);
      oe_n = 1'b0;
      #5 compare_bit(doe, 1'b1);
      repeat (5) tck_cycle(1, 0);
      tck_cycle(0, 0);
      tck_cycle(1, 0);
      tck_cycle(0, 0);
      tck_cycle(0, 0);
      compare_bit(tdo_oe, 1'b1);
      for (int i = 0; i < 4; i++) begin
         tck_cycle(0, i[0]);
         compare_bit(tdo, i[0]);
      end
      trst_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      trst_n <= 1'b1;
      tck_cycle(0, 0);
      compare_bit(tdo_oe, 1'b0);
      // walk to instruction shift: capture value out first, lsb first
      tck_cycle(1, 0);
      tck_cycle(1, 0);
      repeat (2) tck_cycle(0, 0);
      compare_bit(tdo, PSSP_IR_CAPTURE[0]);
      tck_cycle(0, 1);
      compare_bit(tdo, PSSP_IR_CAPTURE[1]);
      tck_cycle(0, 0);
      compare_bit(tdo, 1'b1);
      repeat (4) cmd(0, 1, 3'b000, 0, 4'hf);
      tally_and_finish;
   end
endmodule

// file: core/pssp_array.sv
// lane-writable storage array with registered, write-first read port
`timescale 1ns/1ns
module pssp_array
   import pssp_pkg::*;
#(
   parameter int ADDR_W = PSSP_ADDR_W,
   parameter int LANES  = PSSP_LANES,
   parameter int LANE_W = PSSP_LANE_W
) (
   // clock and reset
   input  wire logic                      i_clock,
   input  wire logic                      i_sys_rst,
   // write port
   input  wire logic                      i_write,
   input  wire logic [ADDR_W-1:0]         i_wr_addr,
   input  wire logic [LANES-1:0]          i_wr_lanes_n,
   input  wire logic [LANES*LANE_W-1:0]   i_wr_data,
   // read port
   input  wire logic                      i_rd_en,
   input  wire logic [ADDR_W-1:0]         i_rd_addr,
   output logic      [LANES*LANE_W-1:0]   o_rd_data
);
   genvar k;
   for (k = 0; k < LANES; k++) begin : g_lane
      logic [LANE_W-1:0] mem [2**ADDR_W];
      wire               we  = i_write & ~i_wr_lanes_n[k];
      wire               fwd = we & (i_wr_addr == i_rd_addr);
      wire [LANE_W-1:0]  wd  = i_wr_data[k*LANE_W +: LANE_W];
      // contents have no reset and survive sleep
      always_ff @(posedge i_clock) begin
         if (we) begin
            mem[i_wr_addr] <= wd; // [R01] [R21]
         end
      end
      always_ff @(posedge i_clock) begin
         if (i_sys_rst) begin
            o_rd_data[k*LANE_W +: LANE_W] <= '0;
         end else if (i_rd_en) begin
            o_rd_data[k*LANE_W +: LANE_W] <= fwd ? wd : mem[i_rd_addr];
         end
      end
   end
endmodule

// file: core/pssp_pkg.sv
// shared constants and types of the pipelined sync sram port
package pssp_pkg;
   localparam int PSSP_ADDR_W  = 19;
   localparam int PSSP_LANES   = 4;
   localparam int PSSP_LANE_W  = 9;
   localparam int PSSP_BYTE_W  = 8;
   localparam int PSSP_DATA_W  = PSSP_LANES * PSSP_LANE_W;
   localparam int PSSP_PINS_W  = PSSP_LANES * PSSP_BYTE_W;
   localparam int PSSP_BURST_W = 2;
   localparam logic [PSSP_BURST_W-1:0] PSSP_BURST_FIRST = 2'h0;
   localparam logic [PSSP_BURST_W-1:0] PSSP_BURST_STEP  = 2'h1;
   localparam logic PSSP_ORDER_LINEAR = 1'b0;
   localparam logic PSSP_RW_READ      = 1'b1;
   localparam logic [PSSP_LANES-1:0] PSSP_LANES_OFF = 4'hf;
   localparam int PSSP_IR_W = 2;
   localparam logic [PSSP_IR_W-1:0] PSSP_IR_CAPTURE = 2'h1;
   localparam logic [PSSP_IR_W-1:0] PSSP_IR_RESET   = 2'h3;

   typedef struct packed {
      logic                    valid;
      logic                    write;
      logic [PSSP_ADDR_W-1:0]  addr;
      logic [PSSP_LANES-1:0]   lanes_n;
   } pssp_cmd_type;

   typedef enum logic [3:0] {
      TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SHIFT_DR, TS_EXIT1_DR,
      TS_PAUSE_DR, TS_EXIT2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR,
      TS_SHIFT_IR, TS_EXIT1_IR, TS_PAUSE_IR, TS_EXIT2_IR, TS_UPD_IR
   } pssp_tap_type;
endpackage

// file: core/pssp_port.sv
// pipelined zero-turnaround sync sram host port, device side
`timescale 1ns/1ns
//Contract
// R01: one low write enable per 9-bit lane
// R02: controller gives lane enables with load write
// R03: controller gives lane enables every burst write
// R04: lane enables ignored on read cycles
// R05: write data taken two cycles after command
// R06: controller may tie all lane enables low
// R07: load while unselected starts a deselect
// R08: bus floats two cycles after deselect
// R09: three selects, all true to select
// R10: everything but output enable on rising edge
// R11: input and output data paths registered
// R12: burst order input picks interleaved or linear
// R13: burst order input held static by system
// R14: output enable high floats bus asynchronously
// R15: controller may hold output enable low
// R16: test inputs sampled on test clock rise
// R17: test output changes on test clock fall
// R18: test output driven only in shift states
// R19: test controller reset by power-up or reset
// R20: sleep gates the internal clock
// R21: contents kept while sleeping
// R22: data transfer two cycles after command
// R23: clock hold freezes inputs, outputs, registers
// R24: load takes address, advance steps counter
// R25: burst gives four transfers per address
// R26: linear counts up, interleaved uses xor
module pssp_port
   import pssp_pkg::*;
(
   // clock and reset
   input  wire logic                    i_clock,
   input  wire logic                    i_sys_rst,
   // command
   input  wire logic [PSSP_ADDR_W-1:0]  i_address,
   input  wire logic                    i_read_write,
   input  wire logic                    i_advance_or_load,
   input  wire logic                    i_select_low_a,
   input  wire logic                    i_select_low_b,
   input  wire logic                    i_select_high,
   input  wire logic [PSSP_LANES-1:0]   i_byte_lane_write_n,
   // static and power controls
   input  wire logic                    i_clock_hold_n,
   input  wire logic                    i_burst_order_select,
   input  wire logic                    i_output_enable_n,
   input  wire logic                    i_sleep_request,
   // data pins
   input  wire logic [PSSP_PINS_W-1:0]  i_data_pins,
   input  wire logic [PSSP_LANES-1:0]   i_byte_parity_pins,
   output logic      [PSSP_PINS_W-1:0]  o_data_pins,
   output logic      [PSSP_LANES-1:0]   o_byte_parity_pins,
   output logic                         o_data_oe,
   // test port
   input  wire logic                    i_test_clock,
   input  wire logic                    i_test_mode,
   input  wire logic                    i_test_data,
   input  wire logic                    i_test_reset_n,
   output logic                         o_test_out,
   output logic                         o_test_out_oe
);
   pssp_cmd_type                 s1_q, s1_d, s2_q, wr_q;
   logic [PSSP_DATA_W-1:0]       wdat_q;
   logic [PSSP_DATA_W-1:0]       pin_word;
   logic [PSSP_DATA_W-1:0]       rd_word;
   logic [PSSP_ADDR_W-1:0]       base_q;
   logic [PSSP_BURST_W-1:0]      cnt_q;
   logic                         burst_q;
   logic                         burst_wr_q;
   logic                         drive_q;

   // sleep and clock hold both act as a gated clock
   wire act   = ~i_clock_hold_n & ~i_sleep_request; // [R20] [R23]
   wire sel   = ~i_select_low_a & ~i_select_low_b
                & i_select_high; // [R09]
   wire load  = ~i_advance_or_load;
   wire ld_rd = load & sel & (i_read_write == PSSP_RW_READ);
   wire ld_wr = load & sel & (i_read_write != PSSP_RW_READ);
   wire step  = ~load & burst_q;
   wire order = i_burst_order_select;

   wire [PSSP_BURST_W-1:0] cnt_nx = cnt_q + PSSP_BURST_STEP;
   wire [PSSP_BURST_W-1:0] base_lo = base_q[PSSP_BURST_W-1:0];
   wire [PSSP_BURST_W-1:0] lo_lin = base_lo + cnt_nx; // [R26]
   wire [PSSP_BURST_W-1:0] lo_il  = base_lo ^ cnt_nx; // [R26]
   wire [PSSP_BURST_W-1:0] lo_nx  =
      (order == PSSP_ORDER_LINEAR) ? lo_lin : lo_il; // [R12]
   wire [PSSP_ADDR_W-1:0]  step_addr =
      {base_q[PSSP_ADDR_W-1:PSSP_BURST_W], lo_nx};

   wire [PSSP_LANES-1:0] ld_lanes =
      ld_wr ? i_byte_lane_write_n : PSSP_LANES_OFF; // [R04]
   wire [PSSP_LANES-1:0] st_lanes =
      burst_wr_q ? i_byte_lane_write_n : PSSP_LANES_OFF; // [R03]

   // next first-stage command
   always_comb begin
      s1_d = '0;
      if (load && sel) begin
         s1_d.valid   = 1'b1; // [R24]
         s1_d.write   = ld_wr;
         s1_d.addr    = i_address;
         s1_d.lanes_n = ld_lanes; // [R01]
      end else if (step) begin
         s1_d.valid   = 1'b1; // [R25]
         s1_d.write   = burst_wr_q;
         s1_d.addr    = step_addr; // [R24]
         s1_d.lanes_n = st_lanes;
      end
   end

   // lane order of the pin word
   genvar k;
   for (k = 0; k < PSSP_LANES; k++) begin : g_pins
      assign pin_word[k*PSSP_LANE_W +: PSSP_LANE_W] =
         {i_byte_parity_pins[k], i_data_pins[k*PSSP_BYTE_W +: PSSP_BYTE_W]};
      assign o_data_pins[k*PSSP_BYTE_W +: PSSP_BYTE_W] =
         rd_word[k*PSSP_LANE_W +: PSSP_BYTE_W];
      assign o_byte_parity_pins[k] =
         rd_word[k*PSSP_LANE_W + PSSP_BYTE_W];
   end

   // burst counter; a load while unselected ends any burst
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         base_q     <= '0;
         cnt_q      <= PSSP_BURST_FIRST;
         burst_q    <= 1'b0;
         burst_wr_q <= 1'b0;
      end else if (act) begin
         if (load) begin
            base_q     <= i_address; // [R24]
            cnt_q      <= PSSP_BURST_FIRST;
            burst_q    <= sel; // [R07]
            burst_wr_q <= ld_wr;
         end else if (burst_q) begin
            cnt_q <= cnt_nx; // [R25]
         end
      end
   end

   // command pipeline, all on the rising edge
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else if (act) begin
         s1_q <= s1_d; // [R10]
         s2_q <= s1_q;
      end
   end

   // write data registered two cycles after the command
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         wr_q   <= '0;
         wdat_q <= '0;
      end else if (act) begin
         wr_q   <= s2_q;
         wdat_q <= pin_word; // [R05] [R11]
      end
   end

   // drive bus in the cycle of a read transfer only
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         drive_q <= 1'b0;
      end else if (act) begin
         drive_q <= s2_q.valid & ~s2_q.write; // [R08] [R22]
      end
   end

   // output enable gates the driver without the clock
   assign o_data_oe = drive_q & ~i_output_enable_n; // [R14]

   pssp_array u_array (
      .i_clock      (i_clock),
      .i_sys_rst    (i_sys_rst),
      .i_write      (act & wr_q.valid & wr_q.write), // [R05] [R21]
      .i_wr_addr    (wr_q.addr),
      .i_wr_lanes_n (wr_q.lanes_n), // [R01]
      .i_wr_data    (wdat_q),
      .i_rd_en      (act), // [R11] [R23]
      .i_rd_addr    (s2_q.addr),
      .o_rd_data    (rd_word)
   );

   pssp_test_port u_test_port (
      .i_clock        (i_clock),
      .i_sys_rst      (i_sys_rst),
      .i_test_clock   (i_test_clock),
      .i_test_mode    (i_test_mode),
      .i_test_data    (i_test_data),
      .i_test_reset_n (i_test_reset_n),
      .o_test_out     (o_test_out),
      .o_test_out_oe  (o_test_out_oe)
   );

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);

   a_read_latency: assert property ( // [R22]
      (act && ld_rd) ##1 act ##1 act |=> drive_q
   ) else $error("read data not driven two cycles after command");

   a_deselect_float: assert property ( // [R07] [R08]
      (act && load && !sel) ##1 act ##1 act |=> !drive_q
   ) else $error("bus still driven two cycles after deselect");

   a_write_lanes: assert property ( // [R05]
      (act && ld_wr) ##1 act ##1 act |=>
         wr_q.valid && wr_q.write
         && wr_q.lanes_n == $past(i_byte_lane_write_n, 3)
         && wdat_q == $past(pin_word)
   ) else $error("write lanes or data not taken two cycles later");

   a_read_no_lanes: assert property ( // [R04]
      s1_q.valid && !s1_q.write |-> s1_q.lanes_n == PSSP_LANES_OFF
   ) else $error("lane enables kept on a read");

   a_hold_freeze: assert property ( // [R23]
      i_clock_hold_n |=> $stable(s1_q) && $stable(drive_q)
         && $stable(o_data_pins) && $stable(cnt_q)
   ) else $error("state moved while clock held");

   a_sleep_freeze: assert property ( // [R20]
      i_sleep_request |=> $stable(s2_q) && $stable(wr_q)
         && $stable(o_byte_parity_pins)
   ) else $error("state moved while sleeping");

   a_burst_linear: assert property ( // [R26]
      (act && step && order == PSSP_ORDER_LINEAR) |=>
         s1_q.addr[PSSP_BURST_W-1:0]
            == $past(s1_q.addr[PSSP_BURST_W-1:0]) + PSSP_BURST_STEP
   ) else $error("linear burst did not count up by one");

   a_burst_interleave: assert property ( // [R12]
      (act && step && order != PSSP_ORDER_LINEAR) |=>
         s1_q.addr[PSSP_BURST_W-1:0] == (base_lo ^ cnt_q)
   ) else $error("interleaved burst address wrong");

   a_oe_gates: assert property ( // [R14]
      o_data_oe |-> drive_q && !i_output_enable_n
   ) else $error("bus driven with output enable high");
endmodule

// file: core/pssp_test_port.sv
// boundary-scan test port pins: state walk, bypass and serial output
`timescale 1ns/1ns
module pssp_test_port
   import pssp_pkg::*;
(
   // clock and reset
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   // test pins
   input  wire logic i_test_clock,
   input  wire logic i_test_mode,
   input  wire logic i_test_data,
   input  wire logic i_test_reset_n,
   output logic      o_test_out,
   output logic      o_test_out_oe
);
   pssp_tap_type         state_q, state_d;
   logic                 tck_q;
   logic [PSSP_IR_W-1:0] ir_q;
   logic                 bypass_q;

   wire rise  = i_test_clock & ~tck_q;
   wire fall  = ~i_test_clock & tck_q;
   wire shift = (state_q == TS_SHIFT_DR) | (state_q == TS_SHIFT_IR);
   wire m     = i_test_mode;

   always_comb begin
      case (state_q)
         TS_RESET:    state_d = m ? TS_RESET    : TS_IDLE;
         TS_IDLE:     state_d = m ? TS_SEL_DR   : TS_IDLE;
         TS_SEL_DR:   state_d = m ? TS_SEL_IR   : TS_CAP_DR;
         TS_CAP_DR:   state_d = m ? TS_EXIT1_DR : TS_SHIFT_DR;
         TS_SHIFT_DR: state_d = m ? TS_EXIT1_DR : TS_SHIFT_DR;
         TS_EXIT1_DR: state_d = m ? TS_UPD_DR   : TS_PAUSE_DR;
         TS_PAUSE_DR: state_d = m ? TS_EXIT2_DR : TS_PAUSE_DR;
         TS_EXIT2_DR: state_d = m ? TS_UPD_DR   : TS_SHIFT_DR;
         TS_UPD_DR:   state_d = m ? TS_SEL_DR   : TS_IDLE;
         TS_SEL_IR:   state_d = m ? TS_RESET    : TS_CAP_IR;
         TS_CAP_IR:   state_d = m ? TS_EXIT1_IR : TS_SHIFT_IR;
         TS_SHIFT_IR: state_d = m ? TS_EXIT1_IR : TS_SHIFT_IR;
         TS_EXIT1_IR: state_d = m ? TS_UPD_IR   : TS_PAUSE_IR;
         TS_PAUSE_IR: state_d = m ? TS_EXIT2_IR : TS_PAUSE_IR;
         TS_EXIT2_IR: state_d = m ? TS_UPD_IR   : TS_SHIFT_IR;
         default:     state_d = m ? TS_SEL_DR   : TS_IDLE;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         tck_q <= 1'b0;
      end else begin
         tck_q <= i_test_clock;
      end
   end

   // state, instruction and bypass move on test clock rise
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || !i_test_reset_n) begin
         state_q  <= TS_RESET; // [R19]
         ir_q     <= PSSP_IR_RESET;
         bypass_q <= 1'b0;
      end else if (rise) begin
         state_q <= state_d; // [R16]
         if (state_q == TS_CAP_IR) begin
            ir_q <= PSSP_IR_CAPTURE;
         end else if (state_q == TS_SHIFT_IR) begin
            ir_q <= {i_test_data, ir_q[PSSP_IR_W-1:1]}; // [R16]
         end
         if (state_q == TS_CAP_DR) begin
            bypass_q <= 1'b0;
         end else if (state_q == TS_SHIFT_DR) begin
            bypass_q <= i_test_data;
         end
      end
   end

   // serial output moves on test clock fall
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || !i_test_reset_n) begin
         o_test_out    <= 1'b0;
         o_test_out_oe <= 1'b0;
      end else if (fall) begin
         o_test_out    <= (state_q == TS_SHIFT_IR) ? ir_q[0] : bypass_q;
         o_test_out_oe <= shift; // [R17] [R18]
      end
   end

   // either reset may also drop the enable between falls
   a_tdo_on_fall: assert property ( // [R17]
      @(posedge i_clock) disable iff (i_sys_rst)
      $changed(o_test_out_oe) |-> $past(fall) || $past(i_sys_rst)
         || !$past(i_test_reset_n)
   ) else $error("test output enable moved off a falling edge");

   a_tdo_shift_only: assert property ( // [R18]
      @(posedge i_clock) disable iff (i_sys_rst)
      $rose(o_test_out_oe) |-> $past(shift)
   ) else $error("test output driven outside a shift state");

   a_test_reset: assert property ( // [R19]
      @(posedge i_clock) disable iff (i_sys_rst)
      !i_test_reset_n |=> state_q == TS_RESET
   ) else $error("test reset did not reset the controller");
endmodule
